// ==== branch_bit_flag_execution.sv ====
// execution unit for branches, bit operations, shifts and flag writes
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - carry branches jump to pc+k+1 on carry clear or, lower form, set.
// - minus and plus branches jump on negative one or zero.
// - signed branches test negative xor overflow, ge on 0, lt on 1.
// - half carry branches jump on its state and change no flag.
// - user bit branches jump on the t flag and change no flag.
// - overflow branches jump on the overflow flag, flags untouched.
// - interrupt state branches jump on the enable bit, not changing it.
// - io bit set and clear force one bit, take 2 cycles, no flags.
// - logical shifts fill with zero in 1 cycle and update z c n v.
// - rotate right puts old carry in bit 7 and bit 0 in carry.
// - arithmetic right shift keeps bit 7 and updates z c n v.
// - bit store copies a register bit into t, bit load writes t back.
// - single flag set and clear ops alter only the named flag.
// - interrupt enable and disable write only the enable bit.
module branch_bit_flag_execution
  import branch_bit_flag_pkg::*;
#(
  parameter int PC_W = PC_W_DEFAULT
) (
  input wire logic i_sys_clk,             // core clock, 25 mhz
  input wire logic i_reset_n,             // async reset, active low
  input wire logic i_valid,               // request present
  input wire exec_req_t i_req,            // operation and operands
  input wire logic [PC_W-1:0] i_pc,       // pc of this instruction
  input wire logic i_flags_wr,            // other unit writes flags
  input wire logic [7:0] i_flags_in,      // flags from other unit
  output logic o_ready,                   // request will be taken
  output logic o_done,                    // instruction complete pulse
  output logic o_pc_load,                 // load pc pulse
  output logic [PC_W-1:0] o_pc_target,    // branch target
  output byte_wr_t o_rd,                  // working register write
  output byte_wr_t o_io,                  // io register write
  output logic [7:0] o_status             // status flags
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef enum logic [0:0] {
    ST_IDLE   = 1'b0,
    ST_SECOND = 1'b1
  } exec_state_t;

  exec_state_t state_reg;
  exec_state_t state_next;
  logic ready_reg;
  logic done_reg;
  logic pc_load_reg;
  logic [PC_W-1:0] pc_target_reg;
  byte_wr_t rd_reg;
  byte_wr_t io_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;

  // ****************************************************************
  // decode
  // ****************************************************************
  wire logic accept = i_valid & ready_reg;
  wire logic is_branch;
  wire logic br_taken;
  wire logic is_shift;
  wire logic [7:0] sh_result;
  wire logic sh_carry;
  wire logic sh_zero;
  wire logic sh_neg;
  wire logic sh_ovf;

  branch_condition u_cond (
    .i_op(i_req.op),
    .i_status(status_reg),
    .o_is_branch(is_branch),
    .o_taken(br_taken)
  );

  shift_unit u_shift (
    .i_op(i_req.op),
    .i_value(i_req.rd_val),
    .i_carry(status_reg[FLAG_C]),
    .o_is_shift(is_shift),
    .o_result(sh_result),
    .o_carry(sh_carry),
    .o_zero(sh_zero),
    .o_negative(sh_neg),
    .o_overflow(sh_ovf)
  );

  wire logic is_set_io = (i_req.op == OP_SET_IO_BIT);
  wire logic is_clr_io = (i_req.op == OP_CLEAR_IO_BIT);
  wire logic is_io = is_set_io | is_clr_io;
  wire logic is_bst = (i_req.op == OP_BIT_STORE_TO_T);
  wire logic is_bld = (i_req.op == OP_BIT_LOAD_FROM_T);
  wire logic is_fset = (i_req.op == OP_FLAG_SET);
  wire logic is_fclr = (i_req.op == OP_FLAG_CLEAR);
  wire logic br_go = is_branch & br_taken;
  wire logic two_cycle = br_go | is_io;
  wire logic [7:0] bit_mask = 8'h01 << i_req.bit_sel;
  wire logic sel_bit = i_req.rd_val[i_req.bit_sel];

  wire logic [PC_W-1:0] k_ext = {{(PC_W-OFFSET_W){i_req.k[OFFSET_W-1]}},
                                 i_req.k};
  wire logic [PC_W-1:0] br_target = i_pc + k_ext + PC_W'(1);

  wire logic [7:0] io_data = is_set_io ? (i_req.io_val | bit_mask)
                                       : (i_req.io_val & ~bit_mask);
  wire logic [7:0] bld_data = status_reg[FLAG_T]
                            ? (i_req.rd_val | bit_mask)
                            : (i_req.rd_val & ~bit_mask);
  wire logic [7:0] rd_data = is_shift ? sh_result : bld_data;
  wire logic rd_wr = accept & (is_shift | is_bld);

  always_comb begin
    status_next = status_reg;
    if (accept) begin
      if (is_shift) begin
        status_next[FLAG_Z] = sh_zero;
        status_next[FLAG_C] = sh_carry;
        status_next[FLAG_N] = sh_neg;
        status_next[FLAG_V] = sh_ovf;
      end else if (is_bst) begin
        status_next[FLAG_T] = sel_bit;
      end else if (is_fset) begin
        // named flag only, enable bit included
        status_next[i_req.bit_sel] = 1'b1;
      end else if (is_fclr) begin
        // named flag only, disable clears the enable bit
        status_next[i_req.bit_sel] = 1'b0;
      end
    end else if (i_flags_wr) begin
      status_next = i_flags_in;
    end
  end

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      // taken branch and io ops hold a second cycle
      ST_IDLE: if (accept && two_cycle) state_next = ST_SECOND;
      ST_SECOND: state_next = ST_IDLE;
    endcase
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_reg <= ST_IDLE;
      ready_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= (state_next == ST_IDLE);
      done_reg <= (accept & ~two_cycle) | (state_reg == ST_SECOND);
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      pc_load_reg <= 1'b0;
      pc_target_reg <= '0;
    end else begin
      // target pc+k+1 on a true condition
      pc_load_reg <= accept & br_go;
      if (accept && br_go) pc_target_reg <= br_target;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rd_reg <= '0;
      io_reg <= '0;
      status_reg <= STATUS_FLAGS_RESET;
    end else begin
      rd_reg <= '{wr: rd_wr, data: rd_data};
      io_reg <= '{wr: accept & is_io, data: io_data};
      status_reg <= status_next;
    end
  end

  assign o_ready = ready_reg;
  assign o_done = done_reg;
  assign o_pc_load = pc_load_reg;
  assign o_pc_target = pc_target_reg;
  assign o_rd = rd_reg;
  assign o_io = io_reg;
  assign o_status = status_reg;

  // ****************************************************************
  // checks
  // ****************************************************************
  exec_req_t req_q;
  logic [7:0] st_q;
  logic [PC_W-1:0] pc_q;
  always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      req_q <= '0;
      st_q <= '0;
      pc_q <= '0;
    end else begin
      req_q <= i_req;
      st_q <= status_reg;
      pc_q <= i_pc;
    end
  end

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_reset_n);

  sequence s_taken;
    accept && br_go;
  endsequence
  sequence s_two_step;
    ##1 (o_pc_load && !o_ready && !o_done) ##1 (o_done && o_ready);
  endsequence

  property p_branch_target;
    s_taken |=> o_pc_target == pc_q + PC_W'(1)
      + {{(PC_W-OFFSET_W){req_q.k[OFFSET_W-1]}}, req_q.k};
  endproperty
  a_branch_target: assert property (p_branch_target)
    else $error("branch target not pc+k+1");

  property p_taken_two_cycles;
    s_taken |-> s_two_step;
  endproperty
  a_taken_two_cycles: assert property (p_taken_two_cycles)
    else $error("taken branch not two cycles");

  property p_untaken_one_cycle;
    accept && is_branch && !br_taken |=> o_done && !o_pc_load;
  endproperty
  a_untaken_one_cycle: assert property (p_untaken_one_cycle)
    else $error("untaken branch not one cycle");

  property p_signed_ge;
    accept && i_req.op == OP_BRANCH_GE_SIGNED
      |=> o_pc_load == !(st_q[FLAG_N] ^ st_q[FLAG_V]);
  endproperty
  a_signed_ge: assert property (p_signed_ge)
    else $error("signed ge branch decision wrong");

  property p_branch_flags_kept;
    accept && is_branch && !i_flags_wr |=> o_status == st_q;
  endproperty
  a_branch_flags_kept: assert property (p_branch_flags_kept)
    else $error("branch changed status flags");

  property p_io_bit;
    accept && is_io |=> o_io.wr && o_status == st_q
      && o_io.data[req_q.bit_sel] == (req_q.op == OP_SET_IO_BIT)
      ##1 o_done && !o_io.wr;
  endproperty
  a_io_bit: assert property (p_io_bit)
    else $error("io bit op wrong value or timing");

  property p_shift_left;
    accept && i_req.op == OP_SHIFT_LEFT_LOGICAL
      |=> o_rd.wr && o_rd.data == {req_q.rd_val[6:0], 1'b0}
      && o_status[FLAG_C] == req_q.rd_val[7] && o_done;
  endproperty
  a_shift_left: assert property (p_shift_left)
    else $error("left shift result wrong");

  property p_rotate_right;
    accept && i_req.op == OP_ROTATE_RIGHT_THROUGH_CARRY
      |=> o_rd.data == {st_q[FLAG_C], req_q.rd_val[7:1]}
      && o_status[FLAG_C] == req_q.rd_val[0];
  endproperty
  a_rotate_right: assert property (p_rotate_right)
    else $error("rotate through carry wrong");

  property p_arith_right;
    accept && i_req.op == OP_ARITH_SHIFT_RIGHT
      |=> o_rd.data[7:6] == {2{req_q.rd_val[7]}};
  endproperty
  a_arith_right: assert property (p_arith_right)
    else $error("arithmetic shift lost sign");

  property p_bit_store;
    accept && is_bst
      |=> o_status[FLAG_T] == req_q.rd_val[req_q.bit_sel] && !o_rd.wr;
  endproperty
  a_bit_store: assert property (p_bit_store)
    else $error("bit store into t wrong");

  property p_flag_only_named;
    accept && (is_fset || is_fclr) |=> o_done
      && o_status[req_q.bit_sel] == (req_q.op == OP_FLAG_SET)
      && ((o_status ^ st_q) & ~(8'h01 << req_q.bit_sel)) == 8'h00;
  endproperty
  a_flag_only_named: assert property (p_flag_only_named)
    else $error("flag op touched another flag");

  property p_irq_branch_keeps;
    accept && i_req.op == OP_BRANCH_IRQ_ENABLED && !i_flags_wr
      |=> o_pc_load == st_q[FLAG_I] && o_status[FLAG_I] == st_q[FLAG_I];
  endproperty
  a_irq_branch_keeps: assert property (p_irq_branch_keeps)
    else $error("interrupt branch wrong");

endmodule // branch_bit_flag_execution
`default_nettype wire

// ==== branch_bit_flag_execution_tb.sv ====
// self-checking testbench for the branch, bit and flag execution unit
`timescale 1ns/10ps
`default_nettype none
module branch_bit_flag_execution_tb
  import branch_bit_flag_pkg::*;
;
  // ************************************************************
  // stimulus and observation signals
  // ************************************************************
  logic i_sys_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_valid = 1'b0;
  exec_req_t i_req = '0;
  logic [15:0] i_pc = 16'h0000;
  logic i_flags_wr = 1'b0;
  logic [7:0] i_flags_in = 8'h00;
  logic o_ready, o_done, o_pc_load;
  logic [15:0] o_pc_target;
  byte_wr_t o_rd, o_io;
  logic [7:0] o_status;
  int errors = 0;
  int cmp_count = 0;
  int r_cyc, i, j, c;
  logic r_load, r_rdy, tk, co;
  logic [15:0] r_tgt, pc;
  byte_wr_t r_rd, r_io;
  logic [7:0] s, v, res, exp_s;
  logic signed [6:0] kk;
  logic [7:0] st_tab [6] = '{8'h00, 8'hff, 8'h04, 8'h0c, 8'h55, 8'haa};
  logic [7:0] val_tab [4] = '{8'h81, 8'h00, 8'h40, 8'h01};

  always #20 i_sys_clk = ~i_sys_clk;

  branch_bit_flag_execution #(.PC_W(16)) uut (
    .i_sys_clk(i_sys_clk), .i_reset_n(i_reset_n), .i_valid(i_valid),
    .i_req(i_req), .i_pc(i_pc), .i_flags_wr(i_flags_wr),
    .i_flags_in(i_flags_in), .o_ready(o_ready), .o_done(o_done),
    .o_pc_load(o_pc_load), .o_pc_target(o_pc_target), .o_rd(o_rd),
    .o_io(o_io), .o_status(o_status));

  // ************************************************************
  // compare and access tasks
  // ************************************************************
  task automatic chk_bit(input string nm, input logic e, input logic g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %b got %b", nm, e, g);
    end
  endtask

  task automatic chk_byte(input string nm, input logic [7:0] e,
                          input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic chk_word(input string nm, input logic [15:0] e,
                          input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask

  // another unit writes the whole flag byte for one cycle
  task automatic set_flags(input logic [7:0] f);
    @(negedge i_sys_clk);
    i_flags_wr = 1'b1;
    i_flags_in = f;
    @(negedge i_sys_clk);
    i_flags_wr = 1'b0;
    chk_byte("status load", f, o_status);
  endtask

  // one request; outputs are gathered at each falling edge until done
  task automatic exec(input exec_op_t op, input logic [2:0] b,
                      input logic signed [6:0] k, input logic [7:0] rd,
                      input logic [7:0] io, input logic [15:0] at);
    int n;
    @(negedge i_sys_clk);
    i_valid = 1'b1;
    i_req.op = op;
    i_req.bit_sel = b;
    i_req.k = k;
    i_req.rd_val = rd;
    i_req.io_val = io;
    i_pc = at;
    n = 0;
    while (o_ready !== 1'b1 && n < 8) begin
      @(negedge i_sys_clk);
      n++;
    end
    @(negedge i_sys_clk);
    i_valid = 1'b0;
    r_cyc = 1;
    r_load = 1'b0;
    r_rdy = o_ready;
    r_rd = '0;
    r_io = '0;
    r_tgt = '0;
    for (n = 0; n < 6; n++) begin
      if (o_pc_load === 1'b1) begin
        r_load = 1'b1;
        r_tgt = o_pc_target;
      end
      if (o_rd.wr === 1'b1) r_rd = o_rd;
      if (o_io.wr === 1'b1) r_io = o_io;
      if (o_done === 1'b1) break;
      @(negedge i_sys_clk);
      r_cyc++;
    end
  endtask

  function automatic logic cond(input exec_op_t op, input logic [7:0] f);
    case (op)
      OP_BRANCH_CARRY_ZERO, OP_BRANCH_SAME_OR_HIGHER: cond = !f[FLAG_C];
      OP_BRANCH_LOWER: cond = f[FLAG_C];
      OP_BRANCH_MINUS: cond = f[FLAG_N];
      OP_BRANCH_PLUS: cond = !f[FLAG_N];
      OP_BRANCH_GE_SIGNED: cond = !(f[FLAG_N] ^ f[FLAG_V]);
      OP_BRANCH_LT_SIGNED: cond = f[FLAG_N] ^ f[FLAG_V];
      OP_BRANCH_HALF_CARRY_ONE: cond = f[FLAG_H];
      OP_BRANCH_HALF_CARRY_ZERO: cond = !f[FLAG_H];
      OP_BRANCH_USER_BIT_ONE: cond = f[FLAG_T];
      OP_BRANCH_USER_BIT_ZERO: cond = !f[FLAG_T];
      OP_BRANCH_OVERFLOW_ONE: cond = f[FLAG_V];
      OP_BRANCH_OVERFLOW_ZERO: cond = !f[FLAG_V];
      OP_BRANCH_IRQ_ENABLED: cond = f[FLAG_I];
      OP_BRANCH_IRQ_DISABLED: cond = !f[FLAG_I];
      default: cond = 1'b0;
    endcase
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ************************************************************
  // watchdog, far beyond the roughly 730 cycles the tests need
  // ************************************************************
  initial begin
    #(40 * 20000);
    errors++;
    $display("[ERR] watchdog expired before the tests ended");
    finish_test();
  end

  // ************************************************************
  // test sequence
  // ************************************************************
  initial begin
    repeat (2) @(negedge i_sys_clk);
    i_reset_n = 1'b1;
    chk_bit("ready after reset", 1'b1, o_ready);
    chk_byte("status after reset", 8'h00, o_status);
    chk_word("target after reset", 16'h0000, o_pc_target);
    $display("test reset done");
    // every branch against flag patterns of both polarities, with wrap
    for (i = 1; i < 16; i++) begin
      for (j = 0; j < 6; j++) begin
        s = st_tab[j];
        kk = 7'(i * 9 + j * 21);
        pc = (j == 5) ? 16'hfffe : 16'h0100;
        tk = cond(exec_op_t'(5'(i)), s);
        set_flags(s);
        exec(exec_op_t'(5'(i)), 3'h0, kk, 8'h00, 8'h00, pc);
        chk_bit("branch taken", tk, r_load);
        chk_word("branch cycles", tk ? 16'h2 : 16'h1, 16'(r_cyc));
        if (tk)
          chk_word("target", pc + {{9{kk[6]}}, kk} + 16'h1, r_tgt);
        chk_byte("branch flags", s, o_status);
      end
    end
    $display("test branches done");
    // io bit forced, two cycles, flags kept
    for (i = 0; i < 8; i++) begin
      for (j = 0; j < 2; j++) begin
        s = o_status;
        v = 8'h01 << i;
        exec(j ? OP_CLEAR_IO_BIT : OP_SET_IO_BIT, 3'(i), 7'h00, 8'h00,
             j ? 8'hff : 8'h00, 16'h0000);
        chk_bit("io write", 1'b1, r_io.wr);
        chk_byte("io data", j ? ~v : v, r_io.data);
        chk_word("io cycles", 16'h2, 16'(r_cyc));
        chk_bit("ready in gap", 1'b0, r_rdy);
        chk_byte("io flags", s, o_status);
      end
    end
    $display("test io bits done");
    // shift results and z c n v, s and h kept
    for (i = 0; i < 4; i++) begin
      for (j = 0; j < 4; j++) begin
        for (c = 0; c < 2; c++) begin
          v = val_tab[j];
          s = 8'h30 | 8'(c);
          case (i)
            0: {co, res} = {v, 1'b0};
            1: {res, co} = {1'b0, v};
            2: {res, co} = {1'(c), v};
            default: {res, co} = {v[7], v};
          endcase
          exp_s = s;
          exp_s[FLAG_C] = co;
          exp_s[FLAG_Z] = (res == 8'h00);
          exp_s[FLAG_N] = res[7];
          exp_s[FLAG_V] = res[7] ^ co;
          set_flags(s);
          exec(exec_op_t'(5'(5'h12 + i)), 3'h0, 7'h00, v, 8'h00, 16'h0000);
          chk_bit("shift write", 1'b1, r_rd.wr);
          chk_byte("shift result", res, r_rd.data);
          chk_byte("shift flags", exp_s, o_status);
          chk_word("shift cycles", 16'h1, 16'(r_cyc));
        end
      end
    end
    $display("test shifts done");
    // bit transfer and single flag writes
    for (i = 0; i < 8; i++) begin
      v = 8'h01 << i;
      set_flags(8'h00);
      exec(OP_BIT_STORE_TO_T, 3'(i), 7'h00, 8'h5a, 8'h00, 16'h0000);
      chk_byte("store t", {1'b0, |(v & 8'h5a), 6'h00}, o_status);
      chk_bit("store no write", 1'b0, r_rd.wr);
      set_flags(8'h40);
      exec(OP_BIT_LOAD_FROM_T, 3'(i), 7'h00, 8'h00, 8'h00, 16'h0000);
      chk_byte("load t one", v, r_rd.data);
      set_flags(8'h00);
      exec(OP_BIT_LOAD_FROM_T, 3'(i), 7'h00, 8'hff, 8'h00, 16'h0000);
      chk_byte("load t zero", ~v, r_rd.data);
      chk_byte("load flags", 8'h00, o_status);
      exec(OP_FLAG_SET, 3'(i), 7'h00, 8'h00, 8'h00, 16'h0000);
      chk_byte("flag set", v, o_status);
      chk_word("flag cycles", 16'h1, 16'(r_cyc));
      set_flags(8'hff);
      exec(OP_FLAG_CLEAR, 3'(i), 7'h00, 8'h00, 8'h00, 16'h0000);
      chk_byte("flag clear", ~v, o_status);
    end
    $display("test bit and flag ops done");
    finish_test();
  end
endmodule // branch_bit_flag_execution_tb
`default_nettype wire

// ==== branch_bit_flag_pkg.sv ====
// shared types and constants for the branch, bit and flag execution slice
package branch_bit_flag_pkg;

  // ****************************************************************
  // status flag bit positions
  // ****************************************************************
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  localparam logic [7:0] STATUS_FLAGS_RESET = 8'h00;

  // ****************************************************************
  // widths and cycle counts
  // ****************************************************************
  localparam int OFFSET_W = 7;
  localparam int PC_W_DEFAULT = 16;
  localparam int BRANCH_TAKEN_CYCLES = 2;
  localparam int BRANCH_NOT_TAKEN_CYCLES = 1;
  localparam int IO_BIT_CYCLES = 2;
  localparam int SINGLE_CYCLES = 1;

  // ****************************************************************
  // operations
  // ****************************************************************
  typedef enum logic [4:0] {
    OP_NOP                   = 5'h00,
    OP_BRANCH_CARRY_ZERO     = 5'h01,
    OP_BRANCH_SAME_OR_HIGHER = 5'h02,
    OP_BRANCH_LOWER          = 5'h03,
    OP_BRANCH_MINUS          = 5'h04,
    OP_BRANCH_PLUS           = 5'h05,
    OP_BRANCH_GE_SIGNED      = 5'h06,
    OP_BRANCH_LT_SIGNED      = 5'h07,
    OP_BRANCH_HALF_CARRY_ONE = 5'h08,
    OP_BRANCH_HALF_CARRY_ZERO = 5'h09,
    OP_BRANCH_USER_BIT_ONE   = 5'h0a,
    OP_BRANCH_USER_BIT_ZERO  = 5'h0b,
    OP_BRANCH_OVERFLOW_ONE   = 5'h0c,
    OP_BRANCH_OVERFLOW_ZERO  = 5'h0d,
    OP_BRANCH_IRQ_ENABLED    = 5'h0e,
    OP_BRANCH_IRQ_DISABLED   = 5'h0f,
    OP_SET_IO_BIT            = 5'h10,
    OP_CLEAR_IO_BIT          = 5'h11,
    OP_SHIFT_LEFT_LOGICAL    = 5'h12,
    OP_SHIFT_RIGHT_LOGICAL   = 5'h13,
    OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h14,
    OP_ARITH_SHIFT_RIGHT     = 5'h15,
    OP_BIT_STORE_TO_T        = 5'h16,
    OP_BIT_LOAD_FROM_T       = 5'h17,
    // flag index in bit_sel: set_carry .. set of the t flag, enable_interrupts
    OP_FLAG_SET              = 5'h18,
    // flag index in bit_sel: clear_carry .. clear_t_flag, disable_interrupts
    OP_FLAG_CLEAR            = 5'h19
  } exec_op_t;

  typedef struct packed {
    exec_op_t op;
    logic [2:0] bit_sel;
    logic signed [OFFSET_W-1:0] k;
    logic [7:0] rd_val;
    logic [7:0] io_val;
  } exec_req_t;

  typedef struct packed {
    logic wr;
    logic [7:0] data;
  } byte_wr_t;

endpackage

// ==== branch_condition.sv ====
// branch condition evaluation against the status flags
`timescale 1ns/10ps
`default_nettype none
module branch_condition
  import branch_bit_flag_pkg::*;
(
  input wire exec_op_t i_op,          // operation
  input wire logic [7:0] i_status,    // current status flags
  output logic o_is_branch,           // op is a conditional branch
  output logic o_taken                // branch condition true
);

  wire logic c_flag = i_status[FLAG_C];
  wire logic n_flag = i_status[FLAG_N];
  wire logic v_flag = i_status[FLAG_V];
  wire logic h_flag = i_status[FLAG_H];
  wire logic t_flag = i_status[FLAG_T];
  wire logic i_flag = i_status[FLAG_I];
  wire logic lt_signed = n_flag ^ v_flag;

  always_comb begin
    o_is_branch = 1'b1;
    o_taken = 1'b0;
    unique case (i_op)
      OP_BRANCH_CARRY_ZERO, OP_BRANCH_SAME_OR_HIGHER: o_taken = ~c_flag;
      OP_BRANCH_LOWER: o_taken = c_flag;
      OP_BRANCH_MINUS: o_taken = n_flag;
      OP_BRANCH_PLUS: o_taken = ~n_flag;
      OP_BRANCH_GE_SIGNED: o_taken = ~lt_signed;
      OP_BRANCH_LT_SIGNED: o_taken = lt_signed;
      OP_BRANCH_HALF_CARRY_ONE: o_taken = h_flag;
      OP_BRANCH_HALF_CARRY_ZERO: o_taken = ~h_flag;
      OP_BRANCH_USER_BIT_ONE: o_taken = t_flag;
      OP_BRANCH_USER_BIT_ZERO: o_taken = ~t_flag;
      OP_BRANCH_OVERFLOW_ONE: o_taken = v_flag;
      OP_BRANCH_OVERFLOW_ZERO: o_taken = ~v_flag;
      OP_BRANCH_IRQ_ENABLED: o_taken = i_flag;
      OP_BRANCH_IRQ_DISABLED: o_taken = ~i_flag;
      default: o_is_branch = 1'b0;
    endcase
  end

endmodule // branch_condition
`default_nettype wire

// ==== shift_unit.sv ====
// shift and rotate of one working register byte with flag results
`timescale 1ns/10ps
`default_nettype none
module shift_unit
  import branch_bit_flag_pkg::*;
(
  input wire exec_op_t i_op,        // operation
  input wire logic [7:0] i_value,   // operand byte
  input wire logic i_carry,         // carry before the op
  output logic o_is_shift,          // op is a shift or rotate
  output logic [7:0] o_result,      // shifted byte
  output logic o_carry,             // bit shifted out
  output logic o_zero,              // result is zero
  output logic o_negative,          // result bit 7
  output logic o_overflow           // negative xor carry
);

  always_comb begin
    o_is_shift = 1'b1;
    o_result = i_value;
    o_carry = i_carry;
    unique case (i_op)
      OP_SHIFT_LEFT_LOGICAL: begin
        o_result = {i_value[6:0], 1'b0};
        o_carry = i_value[7];
      end
      OP_SHIFT_RIGHT_LOGICAL: begin
        o_result = {1'b0, i_value[7:1]};
        o_carry = i_value[0];
      end
      OP_ROTATE_RIGHT_THROUGH_CARRY: begin
        o_result = {i_carry, i_value[7:1]};
        o_carry = i_value[0];
      end
      OP_ARITH_SHIFT_RIGHT: begin
        o_result = {i_value[7], i_value[7:1]};
        o_carry = i_value[0];
      end
      default: o_is_shift = 1'b0;
    endcase
  end

  assign o_zero = (o_result == 8'h00);
  assign o_negative = o_result[7];
  assign o_overflow = o_result[7] ^ o_carry;

endmodule // shift_unit
`default_nettype wire
